/* src/mpp_port_top.v */
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mpp_consts.vh"

module mpp_port_top #(
  parameter P1_WIDTH = 8,
  parameter P3_WIDTH = 8
) (
  input  wire                   core_clk,
  input  wire                   rst,
  // register port
  input  wire [`MPP_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata_ff,
  // port one pins
  input  wire [P1_WIDTH-1:0]    p1_pad_in,
  output wire [P1_WIDTH-1:0]    p1_pad_out,
  output wire [P1_WIDTH-1:0]    p1_pad_oe,
  // port three pins
  input  wire [P3_WIDTH-1:0]    p3_pad_in,
  output wire [P3_WIDTH-1:0]    p3_pad_out,
  output wire [P3_WIDTH-1:0]    p3_pad_oe,
  // core side
  input  wire                   powerdown,
  input  wire                   serial_txd,
  output reg                    serial_rxd_ff,
  output reg                    ext_irq_zero_req_ff,
  output reg                    ext_irq_one_req_ff,
  output reg                    wake_core_ff,
  output reg                    timer_zero_event_ff,
  output reg                    irq_ff
);

  reg [7:0] port_one_value_ff;
  reg [7:0] port_one_direction_ff;
  reg [7:0] port_three_value_ff;
  reg [7:0] port_three_direction_ff;
  reg [7:0] alt_sel_ff;
  reg [`MPP_EV_W-1:0] irq_stat_ff;
  reg [`MPP_EV_W-1:0] irq_mask_ff;
  reg                 t0_prev_ff;

  wire [P1_WIDTH-1:0] p1_sync;
  wire [P3_WIDTH-1:0] p3_sync;

  mpp_sync #(
    .WIDTH   (P1_WIDTH),
    .RST_VAL ({P1_WIDTH{1'b1}})
  ) u_p1_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (p1_pad_in),
    .sync_ff  (p1_sync)
  );

  mpp_sync #(
    .WIDTH   (P3_WIDTH),
    .RST_VAL ({P3_WIDTH{1'b1}})
  ) u_p3_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (p3_pad_in),
    .sync_ff  (p3_sync)
  );

  wire alt_serial = alt_sel_ff[`MPP_ALT_SERIAL];
  wire alt_t0     = alt_sel_ff[`MPP_ALT_TIMER0];
  wire alt_irq0   = alt_sel_ff[`MPP_ALT_IRQ0];
  wire alt_irq1   = alt_sel_ff[`MPP_ALT_IRQ1];

  wire irq0_low   = alt_irq0 & ~p3_sync[`MPP_P3_IRQ0];
  wire irq1_low   = alt_irq1 & ~p3_sync[`MPP_P3_IRQ1];
  wire t0_pin     = p3_sync[`MPP_P3_T0];
  // counting on the falling edge gives one event per full pin pulse
  wire t0_fall    = alt_t0 & t0_prev_ff & ~t0_pin;
  wire wake_cond  = powerdown & (irq0_low | irq1_low);

  // port one cells: no alternate functions
  genvar gi;
  generate
    for (gi = 0; gi < P1_WIDTH; gi = gi + 1) begin : g_p1
      mpp_pin_cell u_cell (
        .core_clk   (core_clk),
        .rst        (rst),
        .alt_en     (1'b0),
        .alt_drive  (1'b0),
        .alt_out    (1'b0),
        .gpio_dir   (port_one_direction_ff[gi]),
        .gpio_val   (port_one_value_ff[gi]),
        .pad_out_ff (p1_pad_out[gi]),
        .pad_oe_ff  (p1_pad_oe[gi])
      );
    end
  endgenerate

  // port three cells: alternate function on bits 0 to 4, general use otherwise
  reg [P3_WIDTH-1:0] p3_alt_en;
  reg [P3_WIDTH-1:0] p3_alt_drive;
  reg [P3_WIDTH-1:0] p3_alt_out;

  always @* begin
    p3_alt_en    = {P3_WIDTH{1'b0}};
    p3_alt_drive = {P3_WIDTH{1'b0}};
    p3_alt_out   = {P3_WIDTH{1'b0}};
    p3_alt_en[`MPP_P3_RXD]    = alt_serial;
    p3_alt_en[`MPP_P3_TXD]    = alt_serial;
    p3_alt_drive[`MPP_P3_TXD] = 1'b1;
    p3_alt_out[`MPP_P3_TXD]   = serial_txd;
    p3_alt_en[`MPP_P3_IRQ0]   = alt_irq0;
    p3_alt_en[`MPP_P3_IRQ1]   = alt_irq1;
    p3_alt_en[`MPP_P3_T0]     = alt_t0;
  end

  generate
    for (gi = 0; gi < P3_WIDTH; gi = gi + 1) begin : g_p3
      mpp_pin_cell u_cell (
        .core_clk   (core_clk),
        .rst        (rst),
        .alt_en     (p3_alt_en[gi]),
        .alt_drive  (p3_alt_drive[gi]),
        .alt_out    (p3_alt_out[gi]),
        .gpio_dir   (port_three_direction_ff[gi]),
        .gpio_val   (port_three_value_ff[gi]),
        .pad_out_ff (p3_pad_out[gi]),
        .pad_oe_ff  (p3_pad_oe[gi])
      );
    end
  endgenerate

  // register write side and events
  wire wr_p1v  = reg_wr & (reg_addr == `MPP_ADDR_P1_VAL);
  wire wr_p1d  = reg_wr & (reg_addr == `MPP_ADDR_P1_DIR);
  wire wr_p3v  = reg_wr & (reg_addr == `MPP_ADDR_P3_VAL);
  wire wr_p3d  = reg_wr & (reg_addr == `MPP_ADDR_P3_DIR);
  wire wr_alt  = reg_wr & (reg_addr == `MPP_ADDR_ALT_SEL);
  wire wr_mask = reg_wr & (reg_addr == `MPP_ADDR_IRQ_MASK);
  wire rd_stat = reg_rd & (reg_addr == `MPP_ADDR_IRQ_STAT);

  reg [`MPP_EV_W-1:0] ev_set;
  reg [`MPP_EV_W-1:0] nxt_irq_stat;
  reg [7:0]           nxt_rdata;

  always @* begin
    ev_set = {`MPP_EV_W{1'b0}};
    ev_set[`MPP_EV_IRQ0] = irq0_low & ~ext_irq_zero_req_ff;
    ev_set[`MPP_EV_IRQ1] = irq1_low & ~ext_irq_one_req_ff;
    ev_set[`MPP_EV_T0]   = t0_fall;
    ev_set[`MPP_EV_WAKE] = wake_cond & ~wake_core_ff;
    // an event in the clearing read's cycle survives it
    nxt_irq_stat = (rd_stat ? {`MPP_EV_W{1'b0}} : irq_stat_ff) | ev_set;
  end

  always @* begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `MPP_ADDR_P1_VAL:   nxt_rdata = port_one_value_ff;
      `MPP_ADDR_P1_DIR:   nxt_rdata = port_one_direction_ff;
      `MPP_ADDR_P3_VAL:   nxt_rdata = port_three_value_ff;
      `MPP_ADDR_P3_DIR:   nxt_rdata = port_three_direction_ff;
      `MPP_ADDR_P1_PINS:  nxt_rdata[P1_WIDTH-1:0] = p1_sync;
      `MPP_ADDR_P3_PINS:  nxt_rdata[P3_WIDTH-1:0] = p3_sync;
      `MPP_ADDR_ALT_SEL:  nxt_rdata = alt_sel_ff;
      `MPP_ADDR_IRQ_STAT: nxt_rdata[`MPP_EV_W-1:0] = irq_stat_ff;
      `MPP_ADDR_IRQ_MASK: nxt_rdata[`MPP_EV_W-1:0] = irq_mask_ff;
      default:            nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      port_one_value_ff       <= `MPP_RST_VAL;
      port_one_direction_ff   <= `MPP_RST_DIR;
      port_three_value_ff     <= `MPP_RST_VAL;
      port_three_direction_ff <= `MPP_RST_DIR;
      alt_sel_ff              <= `MPP_RST_ALT;
      irq_mask_ff             <= `MPP_RST_MASK;
      irq_stat_ff             <= `MPP_RST_STAT;
      reg_rdata_ff            <= 8'h00;
      t0_prev_ff              <= 1'b1;
      serial_rxd_ff           <= 1'b1;
      ext_irq_zero_req_ff     <= 1'b0;
      ext_irq_one_req_ff      <= 1'b0;
      wake_core_ff            <= 1'b0;
      timer_zero_event_ff     <= 1'b0;
      irq_ff                  <= 1'b0;
    end else begin
      if (wr_p1v)
        port_one_value_ff <= reg_wdata;
      if (wr_p1d)
        port_one_direction_ff <= reg_wdata;
      if (wr_p3v)
        port_three_value_ff <= reg_wdata;
      if (wr_p3d)
        port_three_direction_ff <= reg_wdata;
      if (wr_alt)
        alt_sel_ff <= reg_wdata;
      if (wr_mask)
        irq_mask_ff <= reg_wdata[`MPP_EV_W-1:0];
      irq_stat_ff  <= nxt_irq_stat;
      reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
      t0_prev_ff   <= t0_pin;
      // receive line idles high while port three owns the pin
      serial_rxd_ff       <= alt_serial ? p3_sync[`MPP_P3_RXD] : 1'b1;
      ext_irq_zero_req_ff <= irq0_low;
      ext_irq_one_req_ff  <= irq1_low;
      wake_core_ff        <= wake_cond;
      timer_zero_event_ff <= t0_fall;
      irq_ff              <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

endmodule // mpp_port_top

`default_nettype wire

/* src/mpp_consts.vh */
`ifndef MPP_CONSTS_VH
`define MPP_CONSTS_VH

// register indices on the plain register port
`define MPP_ADDR_W           4
`define MPP_ADDR_P1_VAL      4'h0
`define MPP_ADDR_P1_DIR      4'h1
`define MPP_ADDR_P3_VAL      4'h2
`define MPP_ADDR_P3_DIR      4'h3
`define MPP_ADDR_P1_PINS     4'h4
`define MPP_ADDR_P3_PINS     4'h5
`define MPP_ADDR_ALT_SEL     4'h6
`define MPP_ADDR_IRQ_STAT    4'h7
`define MPP_ADDR_IRQ_MASK    4'h8

// reset values
`define MPP_RST_VAL          8'h00
`define MPP_RST_DIR          8'h00
`define MPP_RST_ALT          8'h0F
// event registers are MPP_EV_W bits wide, so their reset values are too
`define MPP_RST_STAT         4'h0
`define MPP_RST_MASK         4'h0

// alternate function select bits
`define MPP_ALT_SERIAL       0
`define MPP_ALT_TIMER0       1
`define MPP_ALT_IRQ0         2
`define MPP_ALT_IRQ1         3

// port three bit positions of the alternate functions
`define MPP_P3_RXD           0
`define MPP_P3_TXD           1
`define MPP_P3_IRQ0          2
`define MPP_P3_IRQ1          3
`define MPP_P3_T0            4

// event status bits
`define MPP_EV_IRQ0          0
`define MPP_EV_IRQ1          1
`define MPP_EV_T0            2
`define MPP_EV_WAKE          3
`define MPP_EV_W             4

`endif

/* src/mpp_sync.v */
`timescale 1ns/1ps
`default_nettype none

module mpp_sync #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_ff
);

  reg [WIDTH-1:0] meta_ff;

  // pins idle high so both stages reset high and no false low edge appears at release
  always @(posedge core_clk) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

endmodule // mpp_sync

`default_nettype wire

/* src/mpp_pin_cell.v */
`timescale 1ns/1ps
`default_nettype none

module mpp_pin_cell (
  input  wire core_clk,
  input  wire rst,
  input  wire alt_en,
  input  wire alt_drive,
  input  wire alt_out,
  input  wire gpio_dir,
  input  wire gpio_val,
  output reg  pad_out_ff,
  output reg  pad_oe_ff
);

  reg nxt_pad_out;
  reg nxt_pad_oe;

  always @* begin
    nxt_pad_out = gpio_val;
    nxt_pad_oe  = gpio_dir;
    if (alt_en) begin
      // an input-only alternate function keeps the driver off whatever the direction bit says
      nxt_pad_out = alt_drive ? alt_out : 1'b0;
      nxt_pad_oe  = alt_drive;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      pad_out_ff <= 1'b0;
      pad_oe_ff  <= 1'b0;
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff  <= nxt_pad_oe;
    end
  end

endmodule // mpp_pin_cell

`default_nettype wire

/* bench/mpp_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module mpp_port_monitor (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic [7:0] p1_pad_out,
  input wire logic [7:0] p1_pad_oe,
  input wire logic [7:0] p3_pad_in,
  input wire logic       powerdown,
  input wire logic       serial_rxd_ff,
  input wire logic       ext_irq_zero_req_ff,
  input wire logic       ext_irq_one_req_ff,
  input wire logic       wake_core_ff,
  input wire logic       timer_zero_event_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_dir_wr; reg_wr && reg_addr == 4'h1; endsequence
  sequence s_val_wr; reg_wr && reg_addr == 4'h0; endsequence
  a_dir_to_oe: assert property (s_dir_wr |-> ##2 p1_pad_oe == $past(reg_wdata, 2))
    else $error("p1 enable does not follow direction write");
  a_val_to_out: assert property (s_val_wr |-> ##2 ((p1_pad_out ^ $past(reg_wdata, 2)) & p1_pad_oe) == 8'h00)
    else $error("p1 drive does not follow value write");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
    else $error("read data outside read slot");
  a_oe_after_reset: assert property ($past(rst) |-> p1_pad_oe == 8'h00)
    else $error("p1 driver on after reset");
  a_req0_pin: assert property (ext_irq_zero_req_ff |-> !$past(p3_pad_in[2], 3))
    else $error("irq0 request without low pin");
  a_req1_pin: assert property (ext_irq_one_req_ff |-> !$past(p3_pad_in[3], 3))
    else $error("irq1 request without low pin");
  a_wake_cause: assert property (wake_core_ff |-> $past(powerdown) && !($past(p3_pad_in[2], 3) && $past(p3_pad_in[3], 3)))
    else $error("wake without powerdown and low irq pin");
  a_t0_one_shot: assert property (timer_zero_event_ff |=> !timer_zero_event_ff)
    else $error("timer event longer than one cycle");
  a_t0_low_pin: assert property (timer_zero_event_ff |-> !$past(p3_pad_in[4], 3))
    else $error("timer event without low pin");
  a_rxd_pin: assert property (!serial_rxd_ff |-> !$past(p3_pad_in[0], 3))
    else $error("receive low without low pin");
endmodule // mpp_port_monitor
bind mpp_port_top mpp_port_monitor u_mon (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .p1_pad_out(p1_pad_out), .p1_pad_oe(p1_pad_oe), .p3_pad_in(p3_pad_in), .powerdown(powerdown),
  .serial_rxd_ff(serial_rxd_ff), .ext_irq_zero_req_ff(ext_irq_zero_req_ff),
  .ext_irq_one_req_ff(ext_irq_one_req_ff), .wake_core_ff(wake_core_ff),
  .timer_zero_event_ff(timer_zero_event_ff));
`default_nettype wire

/* bench/mpp_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mpp_board_model (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] drv,
  output wire logic [7:0] pad_in
);
  // board drives every line the device leaves released; irq lines idle high
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv);
endmodule // mpp_board_model
`default_nettype wire

/* bench/test_mpp_port_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mpp_consts.vh"
module test_mpp_port_top;
  logic       core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, powerdown = 0, serial_txd = 1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, ext1 = 8'h00, ext3 = 8'hFF, rdata, p1_in, p1_out, p1_oe, p3_in, p3_out, p3_oe;
  logic       rxd, rq0, rq1, wake, t0ev, irq;
  integer     err_count = 0, n_tests = 0, seed = 76, cyc = 0, nev = 0, i, v, d, e;
  always #5 core_clk = ~core_clk;
  mpp_port_top u_mpp_port_top (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata), .p1_pad_in(p1_in), .p1_pad_out(p1_out),
    .p1_pad_oe(p1_oe), .p3_pad_in(p3_in), .p3_pad_out(p3_out), .p3_pad_oe(p3_oe), .powerdown(powerdown),
    .serial_txd(serial_txd), .serial_rxd_ff(rxd), .ext_irq_zero_req_ff(rq0), .ext_irq_one_req_ff(rq1),
    .wake_core_ff(wake), .timer_zero_event_ff(t0ev), .irq_ff(irq));
  mpp_board_model brd1 (.pad_out(p1_out), .pad_oe(p1_oe), .drv(ext1), .pad_in(p1_in));
  mpp_board_model brd3 (.pad_out(p3_out), .pad_oe(p3_oe), .drv(ext3), .pad_in(p3_in));
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // the hang limit sits well above the few hundred cycles the sequence needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (t0ev === 1'b1) nev <= nev + 1;
    if (cyc == 4000) begin
      err_count = err_count + 1;
      summarize;
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk(p1_oe, 8'h00);
    rd(`MPP_ADDR_P1_DIR, `MPP_RST_DIR);
    rd(`MPP_ADDR_ALT_SEL, `MPP_RST_ALT);
    rd(4'hF, 8'h00);
    $display("done reset");
    for (i = 0; i < 6; i = i + 1) begin
      v = $random(seed);
      d = $random(seed);
      e = $random(seed);
      @(posedge core_clk) ext1 <= e[7:0];
      wr(`MPP_ADDR_P1_VAL, v[7:0]);
      wr(`MPP_ADDR_P1_DIR, d[7:0]);
      tick(4);
      chk(p1_oe, d[7:0]);
      chk(p1_out & d[7:0], v[7:0] & d[7:0]);
      rd(`MPP_ADDR_P1_PINS, (v[7:0] & d[7:0]) | (e[7:0] & ~d[7:0]));
    end
    $display("done gpio");
    for (i = 0; i < 2; i = i + 1) begin
      wr(`MPP_ADDR_IRQ_MASK, i ? 8'h0F : 8'h00);
      @(posedge core_clk) powerdown <= i[0];
      ext3 <= 8'hFF & ~(8'h04 << i);
      tick(5);
      chk({6'h00, rq1, rq0}, i ? 8'h02 : 8'h01);
      chk({7'h00, wake}, i[7:0]);
      chk({7'h00, irq}, i[7:0]);
      rd(`MPP_ADDR_IRQ_STAT, i ? 8'h0A : 8'h01);
      tick(1);
      chk({7'h00, irq}, 8'h00);
      rd(`MPP_ADDR_IRQ_STAT, 8'h00);
    end
    @(posedge core_clk) ext3 <= 8'hFF;
    powerdown <= 1'b0;
    tick(5);
    $display("done interrupts");
    for (i = 0; i < 2; i = i + 1) begin
      e = nev;
      d = 2 + {$random(seed)} % 3;
      repeat (d) begin
        @(posedge core_clk) ext3[4] <= 1'b0;
        tick(3);
        @(posedge core_clk) ext3[4] <= 1'b1;
        tick(3);
      end
      tick(2);
      v = nev - e;
      chk(v[7:0], i ? 8'h00 : d[7:0]);
      rd(`MPP_ADDR_IRQ_STAT, i ? 8'h00 : 8'h04);
      wr(`MPP_ADDR_ALT_SEL, 8'h0D);
    end
    $display("done timer");
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      @(posedge core_clk) serial_txd <= v[0];
      ext3[0] <= v[1];
      tick(4);
      chk({6'h00, p3_oe[1], p3_out[1]}, {6'h00, 1'b1, v[0]});
      chk({7'h00, rxd}, {7'h00, v[1]});
    end
    wr(`MPP_ADDR_ALT_SEL, 8'h00);
    wr(`MPP_ADDR_P3_DIR, 8'hFF);
    wr(`MPP_ADDR_P3_VAL, v[7:0]);
    tick(3);
    chk(p3_oe, 8'hFF);
    chk(p3_out, v[7:0]);
    chk({7'h00, rxd}, 8'h01);
    rd(`MPP_ADDR_P3_PINS, v[7:0]);
    $display("done serial");
    // reset again with port one lines driven: every port one driver must drop
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk(p1_oe, 8'h00);
    rd(`MPP_ADDR_P1_DIR, `MPP_RST_DIR);
    $display("done mid reset");
    summarize;
  end
endmodule // test_mpp_port_top
`default_nettype wire
